// File: logic/bil_cfg.svh
// How it works
// R1 - size and crc words arrive low byte first
// R2 - program loads at ram zero, starts there
// R3 - crc covers size field plus program bytes
// R4 - reflected poly edb88320, preset ones, inverted
// R5 - spi pins enabled, clock 2.5 mhz
// R6 - send read command, address zero, then read
// R7 - spi mode 0: idle low, rising sample
// R8 - first serial bit lands in bit 0
// R9 - msb-first images need bit-reversed bytes
// R10 - spi boot pins fixed, never reassignable
// R11 - link enabled about 200 ns after start
// R12 - release pulldowns, drive outputs low, watch inputs
// R13 - upstream holds incoming wires low initially
// R14 - allocate endpoint 0, keep ack destination word
// R15 - upstream sends null endpoint for no ack
// R16 - then whole image arrives on endpoint 0
// R17 - crc mismatch: no start, failure flag held
// R18 - slave select low through whole spi transfer
`ifndef BIL_CFG_SVH
`define BIL_CFG_SVH

`define BIL_CLK_HZ       100000000
`define BIL_CLK_NS       10
`define BIL_SCLK_HZ      2500000
`define BIL_SCLK_HALF    (`BIL_CLK_HZ / (2 * `BIL_SCLK_HZ))
`define BIL_LINK_EN_NS   200
`define BIL_LINK_EN_CYC  (`BIL_LINK_EN_NS / `BIL_CLK_NS)
`define BIL_STRAP_CYC    4
`define BIL_CRC_POLY     32'hedb88320
`define BIL_CRC_INIT     32'hffffffff
`define BIL_READ_CMD     8'h03
`define BIL_FLASH_ADDR   24'h000000
`define BIL_NULL_EP      32'h0000ff02
`define BIL_HDR_BITS     32
`define BIL_RAM_AW       16
`define BIL_RAM_DEPTH    65536
`define BIL_PROG_BASE    16'h0000

`endif

// File: logic/bil_pkg.sv
// types shared by the boot image loader
`default_nettype none
package bil_pkg;
   typedef enum logic [2:0] {
      ST_STRAP = 3'b000,
      ST_SPI   = 3'b001,
      ST_LWAIT = 3'b010,
      ST_LINK  = 3'b011,
      ST_RUN   = 3'b100,
      ST_FAIL  = 3'b101
   } bil_state_t;

   typedef enum logic [2:0] {
      PH_ACK  = 3'b000,
      PH_SIZE = 3'b001,
      PH_PROG = 3'b010,
      PH_CRC  = 3'b011,
      PH_END  = 3'b100
   } bil_phase_t;
endpackage
`default_nettype wire

// File: logic/bil_ram.sv
// byte-wide program ram with registered read data
`timescale 1ns/1ps
`default_nettype none
`include "bil_cfg.svh"
module bil_ram (
   // clock
   input  wire logic                   mclk,
   // write port
   input  wire logic                   wr_en,
   input  wire logic [`BIL_RAM_AW-1:0] wr_addr,
   input  wire logic [7:0]             wr_data,
   // read port
   input  wire logic [`BIL_RAM_AW-1:0] rd_addr,
   output logic      [7:0]             rd_data_q
);
   logic [7:0] mem [0:`BIL_RAM_DEPTH-1];

   always_ff @(posedge mclk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      rd_data_q <= mem[rd_addr];
   end
endmodule // bil_ram
`default_nettype wire

// File: logic/bil_loader.sv
// boot image loader: spi flash or link source, crc check, ram fill
`timescale 1ns/1ps
`default_nettype none
`include "bil_cfg.svh"
module bil_loader (
   // clock and reset
   input  wire logic                   mclk,
   input  wire logic                   rst_n,
   // boot source strap, 0 spi flash, 1 link
   input  wire logic                   boot_src_link,
   // spi master pins
   input  wire logic                   spi_miso,
   output logic                        spi_sclk_q,
   output logic                        spi_mosi_q,
   output logic                        spi_ss_n_q,
   output logic                        spi_pins_en_q,
   // link pins
   input  wire logic                   link_in_wire_a,
   input  wire logic                   link_in_wire_b,
   output logic                        link_out_wire_a_q,
   output logic                        link_out_wire_b_q,
   output logic                        link_out_oe_n_q,
   output logic                        link_pulldown_en_q,
   // boot status
   output logic                        ep0_alloc_q,
   output logic      [31:0]            ack_dest_q,
   output logic                        boot_start_q,
   output logic      [`BIL_RAM_AW-1:0] start_addr_q,
   output logic                        boot_fail_q,
   // program ram read port for the core
   input  wire logic [`BIL_RAM_AW-1:0] ram_rd_addr,
   output logic      [7:0]             ram_rd_data_q
);
   bil_pkg::bil_state_t st_q;
   bil_pkg::bil_phase_t ph_q;

   // pin synchronisers
   logic [1:0] strap_s_q, miso_s_q, ina_s_q, inb_s_q;
   logic       ina_d_q, inb_d_q;

   always_ff @(posedge mclk) begin
      strap_s_q <= {strap_s_q[0], boot_src_link};
      miso_s_q  <= {miso_s_q[0], spi_miso};
      ina_s_q   <= {ina_s_q[0], link_in_wire_a};
      inb_s_q   <= {inb_s_q[0], link_in_wire_b};
      ina_d_q   <= ina_s_q[1];
      inb_d_q   <= inb_s_q[1];
   end

   // crc step over one byte, reflected, low bit first
   function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
      logic [31:0] r;
      r = c;
      for (int i = 0; i < 8; i++) begin
         r = (r >> 1) ^ (`BIL_CRC_POLY & {32{r[0] ^ d[i]}});
      end
      return r;
   endfunction

   // counters and shifters
   logic [7:0]  dly_q;
   logic [4:0]  div_q;
   logic [5:0]  hdr_cnt_q;
   logic        hdr_done_q;
   logic [31:0] cmd_sh_q;
   logic [7:0]  spi_sh_q;
   logic [2:0]  spi_bit_q;
   logic        spi_vld_q;
   logic [7:0]  spi_byte_q;
   logic [7:0]  lnk_sh_q;
   logic [2:0]  lnk_bit_q;
   logic        lnk_vld_q;
   logic [7:0]  lnk_byte_q;
   logic [31:0] word_q;
   logic [31:0] size_q;
   logic [31:0] crc_q;
   logic [32:0] cnt_q;
   logic        ok_q;

   // decode
   wire        div_end  = (div_q == 5'(`BIL_SCLK_HALF - 1));
   wire        rise     = (st_q == bil_pkg::ST_SPI) && div_end && !spi_sclk_q;
   wire        fall     = (st_q == bil_pkg::ST_SPI) && div_end && spi_sclk_q;
   wire [7:0]  spi_next = {miso_s_q[1], spi_sh_q[7:1]};
   wire        tok_a    = (ina_s_q[1] != ina_d_q);
   wire        tok_b    = (inb_s_q[1] != inb_d_q);
   wire        tok      = (st_q == bil_pkg::ST_LINK) && (tok_a || tok_b);
   wire [7:0]  lnk_next = {tok_b, lnk_sh_q[7:1]};
   wire        b_vld    = spi_vld_q || lnk_vld_q;
   wire [7:0]  b_dat    = spi_vld_q ? spi_byte_q : lnk_byte_q;
   wire [31:0] word_nx  = {b_dat, word_q[31:8]};
   wire        last4    = (cnt_q[1:0] == 2'h3);
   wire [31:0] crc_nx   = crc_byte(crc_q, b_dat);
   wire        last_pg  = (cnt_q == {1'b0, size_q} - 33'h1);
   wire        too_big  = (word_nx > 32'(`BIL_RAM_DEPTH));
   wire        ram_we   = b_vld && (ph_q == bil_pkg::PH_PROG);
   wire [`BIL_RAM_AW-1:0] ram_wa = `BIL_PROG_BASE + cnt_q[`BIL_RAM_AW-1:0]; // [R2]
   wire        img_end  = (ph_q == bil_pkg::PH_END);

   // spi master, mode 0
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         div_q      <= 5'h00;
         spi_sclk_q <= 1'b0;
         spi_mosi_q <= 1'b0;
         cmd_sh_q   <= {`BIL_READ_CMD, `BIL_FLASH_ADDR}; // [R6]
         hdr_cnt_q  <= 6'h00;
         hdr_done_q <= 1'b0;
         spi_sh_q   <= 8'h00;
         spi_bit_q  <= 3'h0;
         spi_vld_q  <= 1'b0;
         spi_byte_q <= 8'h00;
      end else begin
         spi_vld_q <= 1'b0;
         if (st_q == bil_pkg::ST_SPI && !img_end) begin
            div_q <= div_end ? 5'h00 : div_q + 5'h01; // [R5]
            if (rise) begin
               spi_sclk_q <= 1'b1; // [R7]
               if (hdr_done_q) begin
                  spi_sh_q  <= spi_next; // [R8]
                  spi_bit_q <= spi_bit_q + 3'h1;
                  if (spi_bit_q == 3'h7) begin
                     spi_vld_q  <= 1'b1;
                     spi_byte_q <= spi_next;
                  end
               end
            end else if (fall) begin
               spi_sclk_q <= 1'b0;
               if (!hdr_done_q) begin
                  cmd_sh_q   <= {cmd_sh_q[30:0], 1'b0};
                  spi_mosi_q <= cmd_sh_q[30]; // [R6]
                  hdr_cnt_q  <= hdr_cnt_q + 6'h01;
                  if (hdr_cnt_q == 6'(`BIL_HDR_BITS - 1)) begin
                     hdr_done_q <= 1'b1;
                     spi_mosi_q <= 1'b0;
                  end
               end
            end
         end else if (st_q == bil_pkg::ST_STRAP) begin
            spi_mosi_q <= cmd_sh_q[31];
         end else begin
            spi_sclk_q <= 1'b0; // [R7]
         end
      end
   end

   // link receiver: a transition on wire a is a 0, on wire b a 1
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         lnk_sh_q   <= 8'h00;
         lnk_bit_q  <= 3'h0;
         lnk_vld_q  <= 1'b0;
         lnk_byte_q <= 8'h00;
      end else begin
         lnk_vld_q <= 1'b0;
         if (tok) begin // [R12]
            lnk_sh_q  <= lnk_next;
            lnk_bit_q <= lnk_bit_q + 3'h1;
            if (lnk_bit_q == 3'h7) begin
               lnk_vld_q  <= 1'b1;
               lnk_byte_q <= lnk_next;
            end
         end
      end
   end

   // image parser: ack word, size, program, crc
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         ph_q       <= bil_pkg::PH_SIZE;
         word_q     <= 32'h0;
         size_q     <= 32'h0;
         crc_q      <= `BIL_CRC_INIT; // [R4]
         cnt_q      <= 33'h0;
         ack_dest_q <= 32'h0;
         ok_q       <= 1'b0;
      end else if (st_q == bil_pkg::ST_STRAP) begin
         ph_q <= strap_s_q[1] ? bil_pkg::PH_ACK : bil_pkg::PH_SIZE; // [R14]
      end else if (b_vld) begin
         cnt_q  <= cnt_q + 33'h1;
         word_q <= word_nx; // [R1]
         case (ph_q)
            bil_pkg::PH_ACK: begin
               if (last4) begin
                  ack_dest_q <= word_nx; // [R14]
                  ph_q       <= bil_pkg::PH_SIZE; // [R16]
                  cnt_q      <= 33'h0;
               end
            end
            bil_pkg::PH_SIZE: begin
               crc_q <= crc_nx; // [R3]
               if (last4) begin
                  size_q <= word_nx; // [R1]
                  cnt_q  <= 33'h0;
                  ph_q   <= (word_nx == 32'h0) ? bil_pkg::PH_CRC : bil_pkg::PH_PROG;
                  if (too_big) begin
                     ph_q <= bil_pkg::PH_END;
                  end
               end
            end
            bil_pkg::PH_PROG: begin
               crc_q <= crc_nx; // [R3]
               if (last_pg) begin
                  cnt_q <= 33'h0;
                  ph_q  <= bil_pkg::PH_CRC;
               end
            end
            bil_pkg::PH_CRC: begin
               if (last4) begin
                  ok_q <= (word_nx == ~crc_q); // [R4]
                  ph_q <= bil_pkg::PH_END;
               end
            end
            default: begin
               cnt_q <= cnt_q;
            end
         endcase
      end
   end

   // boot sequencing and pin control
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         st_q               <= bil_pkg::ST_STRAP;
         dly_q              <= 8'h00;
         spi_ss_n_q         <= 1'b1;
         spi_pins_en_q      <= 1'b0;
         link_out_wire_a_q  <= 1'b0;
         link_out_wire_b_q  <= 1'b0;
         link_out_oe_n_q    <= 1'b1;
         link_pulldown_en_q <= 1'b1;
         ep0_alloc_q        <= 1'b0;
         boot_start_q       <= 1'b0;
         start_addr_q       <= `BIL_PROG_BASE;
         boot_fail_q        <= 1'b0;
      end else begin
         dly_q <= dly_q + 8'h01;
         case (st_q)
            bil_pkg::ST_STRAP: begin
               if (dly_q == 8'(`BIL_STRAP_CYC - 1)) begin
                  dly_q <= 8'h00;
                  if (strap_s_q[1]) begin
                     st_q <= bil_pkg::ST_LWAIT;
                  end else begin
                     st_q          <= bil_pkg::ST_SPI;
                     spi_pins_en_q <= 1'b1; // [R5] [R10]
                     spi_ss_n_q    <= 1'b0; // [R18]
                  end
               end
            end
            bil_pkg::ST_SPI: begin
               if (img_end) begin
                  spi_ss_n_q <= 1'b1; // [R18]
                  st_q       <= ok_q ? bil_pkg::ST_RUN : bil_pkg::ST_FAIL;
               end
            end
            bil_pkg::ST_LWAIT: begin
               if (dly_q == 8'(`BIL_LINK_EN_CYC - 1)) begin // [R11]
                  st_q               <= bil_pkg::ST_LINK;
                  link_pulldown_en_q <= 1'b0; // [R12]
                  link_out_oe_n_q    <= 1'b0; // [R12]
                  ep0_alloc_q        <= 1'b1; // [R14]
               end
            end
            bil_pkg::ST_LINK: begin
               if (img_end) begin
                  st_q <= ok_q ? bil_pkg::ST_RUN : bil_pkg::ST_FAIL;
               end
            end
            bil_pkg::ST_RUN: begin
               boot_start_q <= 1'b1; // [R2]
               start_addr_q <= `BIL_PROG_BASE; // [R2]
            end
            bil_pkg::ST_FAIL: begin
               boot_fail_q  <= 1'b1; // [R17]
               boot_start_q <= 1'b0; // [R17]
            end
            default: begin
               st_q <= bil_pkg::ST_FAIL;
            end
         endcase
      end
   end

   bil_ram u_ram (
      .mclk      (mclk),
      .wr_en     (ram_we),
      .wr_addr   (ram_wa),
      .wr_data   (b_dat),
      .rd_addr   (ram_rd_addr),
      .rd_data_q (ram_rd_data_q)
   );
endmodule // bil_loader
`default_nettype wire

// File: tb/bil_loader_sva.sv
// port assertions for the boot image loader
`timescale 1ns/1ps
`default_nettype none
`include "bil_cfg.svh"
module bil_loader_sva (
   // clock and reset
   input wire logic                   mclk,
   input wire logic                   rst_n,
   // spi pins
   input wire logic                   spi_sclk_q,
   input wire logic                   spi_mosi_q,
   input wire logic                   spi_ss_n_q,
   input wire logic                   spi_pins_en_q,
   // link pins
   input wire logic                   link_out_wire_a_q,
   input wire logic                   link_out_wire_b_q,
   input wire logic                   link_out_oe_n_q,
   input wire logic                   link_pulldown_en_q,
   // status
   input wire logic                   ep0_alloc_q,
   input wire logic [31:0]            ack_dest_q,
   input wire logic                   boot_start_q,
   input wire logic [`BIL_RAM_AW-1:0] start_addr_q,
   input wire logic                   boot_fail_q
);
   logic [7:0] lo_q;
   logic [7:0] rel_q;
   always_ff @(posedge mclk) begin
      lo_q  <= (spi_ss_n_q || spi_sclk_q) ? 8'h00 : lo_q + 8'h01;
      rel_q <= !rst_n ? 8'h00 : ((rel_q == 8'hff) ? rel_q : rel_q + 8'h01);
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   AST_SCLK_LOW: assert property ($rose(spi_sclk_q) |-> lo_q == 8'h14)
      else $error("sclk low phase wrong");
   AST_SCLK_IDLE: assert property (spi_ss_n_q && $past(spi_ss_n_q) |-> !spi_sclk_q)
      else $error("sclk not idle low");
   AST_MOSI_HOLD: assert property (spi_sclk_q && $past(spi_sclk_q) |-> $stable(spi_mosi_q))
      else $error("mosi moved while sclk high");
   AST_SS_END: assert property ($rose(spi_ss_n_q) |->
      ##[0:8] (boot_start_q || boot_fail_q))
      else $error("select released before image end");
   AST_PINS_EN: assert property (!spi_ss_n_q |-> spi_pins_en_q && link_out_oe_n_q)
      else $error("spi pins not enabled");
   AST_LINK_IDLE: assert property (!link_out_oe_n_q |->
      !link_out_wire_a_q && !link_out_wire_b_q && !link_pulldown_en_q)
      else $error("link outputs not idle low");
   AST_LINK_EN: assert property ($fell(link_pulldown_en_q) |->
      !link_out_oe_n_q && ep0_alloc_q && rel_q inside {[8'h15:8'h1b]})
      else $error("link enable wrong");
   AST_START_ADDR: assert property ($rose(boot_start_q) |-> start_addr_q == 16'h0000)
      else $error("start address not zero");
   AST_FAIL_STICKY: assert property (boot_fail_q |=> boot_fail_q && !boot_start_q)
      else $error("failure flag not held");
   AST_ACK_HOLD: assert property (boot_start_q && $past(boot_start_q) |->
      $stable(ack_dest_q))
      else $error("ack destination changed");
endmodule // bil_loader_sva
bind bil_loader bil_loader_sva u_bil_loader_sva (.mclk, .rst_n, .spi_sclk_q, .spi_mosi_q,
   .spi_ss_n_q, .spi_pins_en_q, .link_out_wire_a_q, .link_out_wire_b_q, .link_out_oe_n_q,
   .link_pulldown_en_q, .ep0_alloc_q, .ack_dest_q, .boot_start_q, .start_addr_q, .boot_fail_q);
`default_nettype wire

// File: tb/bil_flash_model.sv
// spi flash model, mode 0, image bytes sent lsb first
`timescale 1ns/1ps
`default_nettype none
module bil_flash_model (
   // spi pins
   input  wire logic sclk,
   input  wire logic ss_n,
   input  wire logic mosi,
   output var  logic miso
);
   logic [7:0]  mem [0:63];
   logic [31:0] hdr;
   int          cnt;
   initial begin
      miso = 1'b0;
      cnt = 0;
      hdr = 32'h0;
   end
   always @(negedge ss_n) cnt = 0;
   always @(posedge sclk) begin
      if (!ss_n && cnt < 32) hdr = {hdr[30:0], mosi};
      if (!ss_n) cnt = cnt + 1;
   end
   // data moves after the fall so it is settled at the next rise
   always @(negedge sclk) begin
      if (!ss_n && cnt >= 32) miso = mem[(cnt - 32) / 8][(cnt - 32) % 8];
   end
   // deselected: the line no longer holds the last bit
   always @(posedge ss_n) miso = ~miso;
endmodule // bil_flash_model
`default_nettype wire

// File: tb/tb.sv
// self-checking testbench for the boot image loader
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin num_errors++; \
   $display("unexpected %s expected %h seen %h", nm, e, g); end end
module tb;
   logic        mclk, rst_n, boot_src_link, spi_miso, link_a, link_b;
   logic        sclk, mosi, ss_n, pins_en, out_a, out_b, oe_n, pd_en, ep0, start, fail;
   logic [31:0] ack;
   logic [15:0] saddr, ram_rd_addr;
   logic [7:0]  rdata;
   logic [7:0]  img [0:63];
   int          num_errors = 0;
   int          check_count = 0;
   bil_loader u_bil_loader (.mclk(mclk), .rst_n(rst_n), .boot_src_link(boot_src_link),
      .spi_miso(spi_miso), .spi_sclk_q(sclk), .spi_mosi_q(mosi), .spi_ss_n_q(ss_n),
      .spi_pins_en_q(pins_en), .link_in_wire_a(link_a), .link_in_wire_b(link_b),
      .link_out_wire_a_q(out_a), .link_out_wire_b_q(out_b), .link_out_oe_n_q(oe_n),
      .link_pulldown_en_q(pd_en), .ep0_alloc_q(ep0), .ack_dest_q(ack), .boot_start_q(start),
      .start_addr_q(saddr), .boot_fail_q(fail), .ram_rd_addr(ram_rd_addr), .ram_rd_data_q(rdata));
   bil_flash_model u_bil_flash_model (.sclk(sclk), .ss_n(ss_n), .mosi(mosi), .miso(spi_miso));
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   task automatic complete_run();
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic build(input int n, input logic bad);
      logic [31:0] c;
      int i, k;
      c = 32'hffffffff;
      for (i = 0; i < 4; i++) img[i] = 8'(n >> (8 * i));
      for (i = 0; i < n; i++) img[4 + i] = 8'(i * 37 + 5);
      for (i = 0; i < n + 4; i++) begin
         for (k = 0; k < 8; k++) c = (c[0] ^ img[i][k]) ? (c >> 1) ^ 32'hedb88320 : c >> 1;
      end
      c = ~c ^ {31'h0, bad};
      for (i = 0; i < 4; i++) img[n + 4 + i] = c[8 * i +: 8];
      for (i = 0; i < n + 8; i++) u_bil_flash_model.mem[i] = img[i];
   endtask
   task automatic do_reset(input logic src);
      @(posedge mclk);
      #1 rst_n = 1'b0;
      boot_src_link = src;
      link_a = 1'b0;
      link_b = 1'b0;
      repeat (3) @(posedge mclk);
      #1 rst_n = 1'b1;
   endtask
   task automatic wait_for(input int lim);
      int i;
      for (i = 0; i < lim && start !== 1'b1 && fail !== 1'b1; i++) @(posedge mclk);
      if (i == lim) begin
         num_errors++;
         complete_run();
      end
      repeat (4) @(posedge mclk);
      #1;
   endtask
   task automatic check_ram(input int n);
      int i;
      for (i = 0; i < n; i++) begin
         ram_rd_addr = 16'(i);
         repeat (2) @(posedge mclk);
         #1;
         `CHK("ram byte", img[4 + i], rdata)
      end
   endtask
   task automatic send_byte(input logic [7:0] b);
      int k;
      for (k = 0; k < 8; k++) begin
         if (b[k]) link_b = ~link_b;
         else link_a = ~link_a;
         repeat (4) @(posedge mclk);
         #1;
      end
   endtask
   task automatic spi_good();
      build(9, 1'b0);
      do_reset(1'b0);
      wait_for(20000);
      `CHK("command", 32'h03000000, u_bil_flash_model.hdr)
      `CHK("start", 1'b1, start)
      `CHK("fail", 1'b0, fail)
      `CHK("select", 1'b1, ss_n)
      `CHK("pins enabled", 1'b1, pins_en)
      `CHK("start address", 16'h0000, saddr)
      check_ram(9);
      $display("test spi_good done");
   endtask
   task automatic spi_bad_crc();
      build(5, 1'b1);
      do_reset(1'b0);
      wait_for(20000);
      `CHK("start", 1'b0, start)
      `CHK("fail", 1'b1, fail)
      $display("test spi_bad_crc done");
   endtask
   task automatic spi_size_edges();
      build(0, 1'b0);
      do_reset(1'b0);
      wait_for(20000);
      `CHK("empty start", 1'b1, start)
      `CHK("empty fail", 1'b0, fail)
      u_bil_flash_model.mem[2] = 8'h02;
      do_reset(1'b0);
      wait_for(20000);
      `CHK("oversize start", 1'b0, start)
      `CHK("oversize fail", 1'b1, fail)
      $display("test spi_size_edges done");
   endtask
   task automatic link_boot();
      int i;
      build(6, 1'b0);
      do_reset(1'b1);
      for (i = 0; i < 100 && pd_en !== 1'b0; i++) @(posedge mclk);
      #1;
      `CHK("link enable time", 1'b1, i >= 20 && i <= 30)
      `CHK("endpoint 0", 1'b1, ep0)
      repeat (5) @(posedge mclk);
      #1;
      for (i = 0; i < 4; i++) send_byte(8'(32'h0000ff02 >> (8 * i)));
      for (i = 0; i < 14; i++) send_byte(img[i]);
      wait_for(2000);
      `CHK("ack dest", 32'h0000ff02, ack)
      `CHK("start", 1'b1, start)
      `CHK("out wires", 2'b00, {out_a, out_b})
      `CHK("link drive enable", 1'b0, oe_n)
      check_ram(6);
      $display("test link_boot done");
   endtask
   initial begin
      rst_n = 1'b0;
      boot_src_link = 1'b0;
      link_a = 1'b0;
      link_b = 1'b0;
      ram_rd_addr = 16'h0000;
      spi_good();
      spi_bad_crc();
      spi_size_edges();
      link_boot();
      complete_run();
   end
endmodule // tb
`default_nettype wire
